// ### wbhrb_pkg.sv
package wbhrb_pkg;

    // Widths of the processor side, the ROM side and the generated address bits.
    localparam int unsigned UPPER_W = 14;
    localparam int unsigned LOW_W = 2;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned NUM_READS = 4;
    localparam int unsigned DWORD_W = HALF_W * NUM_READS;
    localparam int unsigned ROM_ADDR_W = UPPER_W + LOW_W;

    // Generated low address bits for the first halfword and the last one.
    localparam logic [LOW_W-1:0] LOW_FIRST = 2'h0;
    localparam logic [LOW_W-1:0] LOW_LAST = 2'h3;
    localparam logic [LOW_W-1:0] LOW_STEP = 2'h1;

    // Wait counter: idle value, first count, and the counts at which events are issued.
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_IDLE = 4'h0;
    localparam logic [CNT_W-1:0] CNT_FIRST = 4'h1;
    localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;
    localparam logic [CNT_W-1:0] CNT_FLAG_AT = 4'h7;
    localparam logic [CNT_W-1:0] CNT_LATCH_AT = 4'h8;
    localparam logic [CNT_W-1:0] CNT_NEXT_AT = 4'h9;
    localparam logic [CNT_W-1:0] CNT_LAST = 4'hA;

    // Control sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CHECK = 3'h1,
        ST_DECODE = 3'h2,
        ST_READ0 = 3'h3,
        ST_READ1 = 3'h4,
        ST_READ2 = 3'h5,
        ST_READ3 = 3'h6,
        ST_DECIDE = 3'h7
    } wbhrb_ctrl_t;

    localparam logic [2:0] ST_STEP = 3'h1;

    // Processor bus signals, all active high here.
    typedef struct packed {
        logic transfer_start;
        logic data_bus_busy;
        logic read_not_write;
        logic [UPPER_W-1:0] upper_rom_address_bits;
    } wbhrb_bus_t;

    // Signals from the external address decode.
    typedef struct packed {
        logic rom_chip_select;
        logic rom_redirect;
    } wbhrb_dec_t;

    // Wait counter state.
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic next_pulse;
        logic early_flag;
        logic latch_strobe;
    } wbhrb_cnt_t;

    // Control sequencer state, including the ROM address and the halfword latches.
    typedef struct packed {
        wbhrb_ctrl_t state;
        logic run;
        logic [ROM_ADDR_W-1:0] rom_address;
        logic [NUM_READS-1:0][HALF_W-1:0] read_data;
    } wbhrb_top_t;

endpackage

// ### wbhrb_wait_counter.sv
`timescale 1ns/1ps
module wbhrb_wait_counter
    import wbhrb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic abort,
    input wire logic last,
    output logic next_pulse,
    output logic early_flag,
    output logic latch_strobe
);

    wbhrb_cnt_t q;
    wbhrb_cnt_t d;

    // Ten further counts after a start; abort drops straight back to idle.
    always_comb begin
        d = q;
        d.next_pulse = 1'b0;
        d.early_flag = 1'b0;
        d.latch_strobe = 1'b0;
        if (abort) begin
            d.count = CNT_IDLE;
        end else if (q.count == CNT_IDLE) begin
            if (run) begin
                d.count = CNT_FIRST;
            end
        end else if (q.count == CNT_LAST) begin
            d.count = CNT_IDLE;
        end else begin
            d.count = q.count + CNT_STEP;
        end
        if (!abort) begin
            d.next_pulse = (q.count == CNT_NEXT_AT);
            d.early_flag = (q.count == CNT_FLAG_AT) && last;
            d.latch_strobe = (q.count == CNT_LATCH_AT);
        end
    end

    // State register.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign next_pulse = q.next_pulse;
    assign early_flag = q.early_flag;
    assign latch_strobe = q.latch_strobe;

endmodule

// ### wbhrb_bridge.sv
`timescale 1ns/1ps
// Contract
// - Four halfword ROM reads per 64-bit operand.
// - ROM address upper fourteen bits from processor.
// - Low two address bits change every read.
// - Each halfword captured into its own latch.
// - Always return a full 64-bit operand.
// - Respond only while redirect is negated.
// - Writes start no ROM access.
// - Early flag exactly two clocks before data.
// - Bus busy negation returns sequencer and counter to idle; address and latches hold.
// - Wait counter runs ten further single-clock states.
// - Decide: idle, new access, or continue burst.
module wbhrb_bridge
    import wbhrb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire wbhrb_bus_t bus,
    input wire wbhrb_dec_t dec,
    input wire logic [HALF_W-1:0] rom_data,
    output logic [ROM_ADDR_W-1:0] rom_address,
    output logic [DWORD_W-1:0] read_data,
    output logic early_completion_flag
);

    wbhrb_top_t q;
    wbhrb_top_t d;
    logic ctr_next;
    logic ctr_latch;
    logic ctr_early;
    logic last_half;
    logic accept;
    logic [NUM_READS-1:0][HALF_W-1:0] lane_d;

    // The fourth halfword is the one whose generated bits are all ones.
    assign last_half = (q.rom_address[LOW_W-1:0] == LOW_LAST);

    // A new access needs a read, no redirect, and the chip select.
    assign accept = bus.data_bus_busy && bus.read_not_write && !dec.rom_redirect
        && dec.rom_chip_select;

    wbhrb_wait_counter u_wait (
        .clk(clk),
        .reset(reset),
        .run(q.run),
        .abort(!bus.data_bus_busy),
        .last(last_half),
        .next_pulse(ctr_next),
        .early_flag(ctr_early),
        .latch_strobe(ctr_latch)
    );

    // Each latch pair loads only when the generated bits point at it, so the
    // earlier halfwords hold while later ones are fetched.
    for (genvar k = 0; k < NUM_READS; k++) begin : g_lane
        assign lane_d[k] = (ctr_latch && q.rom_address[LOW_W-1:0] == LOW_W'(k)) ?
            rom_data : q.read_data[k];
    end

    // Control sequencer. The counter is started by a one-clock run pulse on
    // entry to each read state, and its completion pulse moves the sequence on.
    always_comb begin
        d = q;
        d.run = 1'b0;
        d.read_data = lane_d;
        case (q.state)
            ST_IDLE: begin
                if (bus.transfer_start) begin
                    d.state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (bus.data_bus_busy && bus.read_not_write && !dec.rom_redirect) begin
                    d.state = ST_DECODE;
                end else begin
                    d.state = ST_IDLE;
                end
            end
            ST_DECODE: begin
                if (accept) begin
                    d.state = ST_READ0;
                    d.run = 1'b1;
                    d.rom_address = {bus.upper_rom_address_bits, LOW_FIRST};
                end else begin
                    d.state = ST_IDLE;
                end
            end
            ST_READ0, ST_READ1, ST_READ2: begin
                if (!bus.data_bus_busy) begin
                    d.state = ST_IDLE;
                end else if (ctr_next) begin
                    d.state = wbhrb_ctrl_t'(q.state + ST_STEP);
                    d.run = 1'b1;
                    d.rom_address[LOW_W-1:0] = q.rom_address[LOW_W-1:0] + LOW_STEP;
                end
            end
            ST_READ3: begin
                if (!bus.data_bus_busy) begin
                    d.state = ST_IDLE;
                end else if (ctr_next) begin
                    d.state = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                if (bus.transfer_start) begin
                    d.state = ST_DECODE;
                end else if (bus.data_bus_busy) begin
                    d.state = ST_CHECK;
                end else begin
                    d.state = ST_IDLE;
                end
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase
    end

    // State register; the bus-busy abort above does the functional reset.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rom_address = q.rom_address;
    assign read_data = q.read_data;
    assign early_completion_flag = ctr_early;

    // Assertions.
    AST_FLAG_TWO_BEFORE: assert property (@(posedge clk) disable iff (reset)
        early_completion_flag |-> ##2 (ctr_next && q.state == ST_READ3))
        else $error("Early flag not two clocks before data valid.");

    AST_TEN_STATES: assert property (@(posedge clk)
        disable iff (reset || !bus.data_bus_busy)
        q.run |-> ##2 (!ctr_next) [*8] ##1 ctr_next)
        else $error("Read completion not ten clocks after start.");

    AST_UPPER_ADDR: assert property (@(posedge clk) disable iff (reset)
        (q.state == ST_READ0 && q.run) |->
        q.rom_address[ROM_ADDR_W-1:LOW_W] == $past(bus.upper_rom_address_bits))
        else $error("ROM upper address not taken from processor address.");

    AST_LOW_BITS: assert property (@(posedge clk) disable iff (reset)
        (q.state inside {ST_READ0, ST_READ1, ST_READ2, ST_READ3}) |->
        q.rom_address[LOW_W-1:0] == LOW_W'(q.state - ST_READ0))
        else $error("Generated low address bits out of step with read.");

    AST_REDIRECT: assert property (@(posedge clk) disable iff (reset)
        (q.state == ST_CHECK && dec.rom_redirect) |=> q.state == ST_IDLE)
        else $error("Access taken while redirect asserted.");

    AST_NO_WRITE: assert property (@(posedge clk) disable iff (reset)
        (q.state == ST_CHECK && !bus.read_not_write) |=> (q.state == ST_IDLE && !q.run))
        else $error("Write started a ROM access.");

    AST_ABORT: assert property (@(posedge clk) disable iff (reset)
        (q.state inside {ST_DECODE, ST_READ0, ST_READ1, ST_READ2, ST_READ3}
        && !bus.data_bus_busy) |=> (q.state == ST_IDLE) ##1 !ctr_next)
        else $error("Bus busy negation did not return to idle.");

    AST_LATCH: assert property (@(posedge clk) disable iff (reset)
        ctr_latch |=> q.read_data[$past(q.rom_address[LOW_W-1:0])] == $past(rom_data))
        else $error("Halfword not captured into its latch pair.");

    AST_FLAG_LAST: assert property (@(posedge clk) disable iff (reset)
        early_completion_flag |-> (last_half && q.state == ST_READ3))
        else $error("Early flag outside the fourth read.");

    AST_DECIDE_NEW: assert property (@(posedge clk) disable iff (reset)
        (q.state == ST_DECIDE && bus.transfer_start) |=> q.state == ST_DECODE)
        else $error("Back-to-back start not taken from decide.");

    AST_DECIDE_BURST: assert property (@(posedge clk) disable iff (reset)
        (q.state == ST_DECIDE && !bus.transfer_start && bus.data_bus_busy)
        |=> q.state == ST_CHECK)
        else $error("Burst not continued from decide.");

    AST_DECIDE_IDLE: assert property (@(posedge clk) disable iff (reset)
        (q.state == ST_DECIDE && !bus.transfer_start && !bus.data_bus_busy)
        |=> q.state == ST_IDLE)
        else $error("Finished access did not return to idle.");

    AST_NO_CHIP_SELECT: assert property (@(posedge clk) disable iff (reset)
        (q.state == ST_DECODE && !dec.rom_chip_select) |=> (q.state == ST_IDLE && !q.run))
        else $error("Access started without chip select.");

    // Latches move only on a strobe, so a refused access leaves them intact and an aborted one changes only the halfwords already captured.
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (reset)
        !ctr_latch |=> q.read_data == $past(q.read_data))
        else $error("Latch pair changed without a capture strobe.");

    AST_FLAG_PULSE: assert property (@(posedge clk) disable iff (reset)
        early_completion_flag |=> !early_completion_flag)
        else $error("Early flag held for more than one clock.");

    // A run held until the counter returns to idle would start a second, unwanted count.
    AST_RUN_PULSE: assert property (@(posedge clk) disable iff (reset)
        q.run |=> !q.run)
        else $error("Counter start held for more than one clock.");

    // Main scenarios.
    COV_FULL_READ: cover property (@(posedge clk) disable iff (reset)
        q.state == ST_READ3 ##1 q.state == ST_DECIDE);
    COV_BURST: cover property (@(posedge clk) disable iff (reset)
        q.state == ST_DECIDE ##1 q.state == ST_CHECK);
    COV_BACK_TO_BACK: cover property (@(posedge clk) disable iff (reset)
        q.state == ST_DECIDE ##1 q.state == ST_DECODE);
    COV_ABORT: cover property (@(posedge clk) disable iff (reset)
        q.state == ST_READ1 && !bus.data_bus_busy);
    COV_REFUSE: cover property (@(posedge clk) disable iff (reset)
        q.state == ST_CHECK ##1 q.state == ST_IDLE);

endmodule

// ### wbhrb_rom_model.sv
`timescale 1ns/1ps
// Behavioural halfword ROM with a fixed access time in clocks.
module wbhrb_rom_model
    import wbhrb_pkg::*;
#(
    parameter int LAT = 6
)(
    input wire logic clk,
    input wire logic [ROM_ADDR_W-1:0] rom_address,
    output logic [HALF_W-1:0] rom_data
);
    logic [ROM_ADDR_W-1:0] addr_q = '0;
    int wait_q = 0;
    initial rom_data = 16'h0000;
    // Data toggles until the access time has passed, so an early capture is never lucky.
    always @(posedge clk) begin
        addr_q <= rom_address;
        if (rom_address != addr_q) begin
            wait_q <= LAT;
            rom_data <= ~rom_data;
        end else if (wait_q != 0) begin
            wait_q <= wait_q - 1;
            rom_data <= ~rom_data;
        end else begin
            rom_data <= {rom_address[7:0] ^ 8'h5A, rom_address[15:8] ^ 8'hC3};
        end
    end
endmodule

// ### test_wide_bus_to_halfword_rom_bridge.sv
`timescale 1ns/1ps
module test_wide_bus_to_halfword_rom_bridge
    import wbhrb_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    wbhrb_bus_t bus = '0;
    wbhrb_dec_t dec = '0;
    logic [HALF_W-1:0] rom_data;
    logic [ROM_ADDR_W-1:0] rom_address;
    logic [DWORD_W-1:0] read_data;
    logic early_completion_flag;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    wbhrb_bridge dut (.clk(clk), .reset(reset), .bus(bus), .dec(dec), .rom_data(rom_data),
        .rom_address(rom_address), .read_data(read_data),
        .early_completion_flag(early_completion_flag));
    wbhrb_rom_model #(.LAT(6)) rom (.clk(clk), .rom_address(rom_address), .rom_data(rom_data));

    // Outside acknowledge path: pretransfer one clock after the flag, transfer one more.
    logic pretransfer_ack = 1'b0;
    logic transfer_ack = 1'b0;
    always @(posedge clk) begin
        pretransfer_ack <= early_completion_flag;
        transfer_ack <= pretransfer_ack;
    end

    // The clock and a ceiling on run length, so a hung handshake still ends the run.
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count = fail_count + 1;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Expected double word, lane k holding the halfword at low address k.
    function automatic logic [63:0] dword(input logic [13:0] up);
        logic [15:0] a;
        logic [63:0] d;
        d = '0;
        for (int k = 0; k < 4; k++) begin
            a = {up, k[1:0]};
            d[16*k +: 16] = {a[7:0] ^ 8'h5A, a[15:8] ^ 8'hC3};
        end
        return d;
    endfunction

    // One-clock start pulse, then bus busy from the second clock.
    task automatic start(input logic [13:0] up, input logic rnw, cs, rd, bsy);
        bus.transfer_start = 1'b1;
        bus.upper_rom_address_bits = up;
        bus.read_not_write = rnw;
        dec = '{rom_chip_select: cs, rom_redirect: rd};
        @(negedge clk);
        bus.transfer_start = 1'b0;
        bus.data_bus_busy = bsy;
    endtask

    // Waits for the early flag, checks its clock and the data two clocks later; ends in c47.
    task automatic word(input logic [13:0] up, input int exp_n);
        int n;
        n = 0;
        while (n < 60 && early_completion_flag !== 1'b1) begin
            @(negedge clk);
            n++;
        end
        chk("flag clock", 64'(exp_n), 64'(n));
        chk("address on flag", 64'({up, LOW_LAST}), 64'(rom_address));
        @(negedge clk);
        chk("pretransfer ack", 64'h1, 64'(pretransfer_ack));
        @(negedge clk);
        chk("transfer ack", 64'h1, 64'(transfer_ack));
        chk("flag gone", 64'h0, 64'(early_completion_flag));
        chk("double word", dword(up), read_data);
        @(negedge clk);
    endtask

    task automatic single(input logic [13:0] up);
        start(up, 1'b1, 1'b1, 1'b0, 1'b1);
        word(up, 43);
        bus.data_bus_busy = 1'b0;
        @(negedge clk);
        $display("test single %h done", up);
    endtask

    // A refused access must leave address, latches and flag untouched.
    task automatic refuse(input logic rnw, cs, rd, bsy);
        logic [63:0] d;
        logic [15:0] a;
        d = read_data;
        a = rom_address;
        start(14'h2AAA, rnw, cs, rd, bsy);
        repeat (60) begin
            @(negedge clk);
            chk("no flag", 64'h0, 64'(early_completion_flag));
        end
        chk("address kept", 64'(a), 64'(rom_address));
        chk("latches kept", d, read_data);
        bus.data_bus_busy = 1'b0;
        @(negedge clk);
        $display("test refuse %b%b%b%b done", rnw, cs, rd, bsy);
    endtask

    // Back-to-back: the next start in the clock after the transfer acknowledge.
    task automatic back_to_back();
        start(14'h0123, 1'b1, 1'b1, 1'b0, 1'b1);
        word(14'h0123, 43);
        bus.data_bus_busy = 1'b0;
        start(14'h3210, 1'b1, 1'b1, 1'b0, 1'b1);
        word(14'h3210, 42);
        bus.data_bus_busy = 1'b0;
        @(negedge clk);
        $display("test back_to_back done");
    endtask

    // Burst of four double words with busy held and the next address after each ack.
    task automatic burst();
        start(14'h1000, 1'b1, 1'b1, 1'b0, 1'b1);
        word(14'h1000, 43);
        for (int i = 1; i < 4; i++) begin
            bus.upper_rom_address_bits = 14'(14'h1000 + i);
            word(14'(14'h1000 + i), 44);
        end
        bus.data_bus_busy = 1'b0;
        @(negedge clk);
        $display("test burst done");
    endtask

    // Busy dropping mid-read must abandon the access and leave the block idle.
    task automatic abort();
        start(14'h0555, 1'b1, 1'b1, 1'b0, 1'b1);
        repeat (20) @(negedge clk);
        bus.data_bus_busy = 1'b0;
        repeat (40) begin
            @(negedge clk);
            chk("abort flag", 64'h0, 64'(early_completion_flag));
        end
        single(14'h0AAA);
        $display("test abort done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        chk("flag after reset", 64'h0, 64'(early_completion_flag));
        single(14'h3FFF);
        refuse(1'b0, 1'b1, 1'b0, 1'b1);
        refuse(1'b1, 1'b1, 1'b1, 1'b1);
        refuse(1'b1, 1'b0, 1'b0, 1'b1);
        refuse(1'b1, 1'b1, 1'b0, 1'b0);
        back_to_back();
        burst();
        abort();
        wrap_up();
    end
endmodule
